//--- hsmc_regs.svh
// Constants for the host serial mode control block
`ifndef HSMC_REGS_SVH
`define HSMC_REGS_SVH
`define HSMC_CLK_HZ 100000000
`define HSMC_DIV_9600 (`HSMC_CLK_HZ / 9600)
`define HSMC_DIV_19200 (`HSMC_CLK_HZ / 19200)
`define HSMC_DIV_38400 (`HSMC_CLK_HZ / 38400)
`define HSMC_DIV_57600 (`HSMC_CLK_HZ / 57600)
`define HSMC_DIV_115200 (`HSMC_CLK_HZ / 115200)
`define HSMC_GUARD_MS 1000
`define HSMC_GUARD_CYC (`HSMC_CLK_HZ / 1000 * `HSMC_GUARD_MS)
`define HSMC_PLUS_CHAR 8'h2B
`define HSMC_DATA_BITS 8
`endif

//--- hsmc_pkg.sv
// Types for the host serial mode control block
package hsmc_pkg;
  typedef enum logic [2:0] {
    RATE_9600,
    RATE_19200,
    RATE_38400,
    RATE_57600,
    RATE_115200
  } hsmc_rate_t;
  typedef enum logic [1:0] {
    LINE_IDLE,
    LINE_START,
    LINE_DATA,
    LINE_STOP
  } hsmc_line_t;
  typedef enum logic [2:0] {
    ESC_WAIT,
    ESC_ARMED,
    ESC_PLUS1,
    ESC_PLUS2,
    ESC_PLUS3
  } hsmc_esc_t;
  typedef enum logic {
    MODE_OFFLINE,
    MODE_ONLINE
  } hsmc_mode_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hsmc_byte_t;
endpackage

//--- hsmc_top.sv
// Host serial port with offline/online mode and guarded escape detection
`timescale 1ns/1ns
`default_nettype none
`include "hsmc_regs.svh"
module hsmc_top #(
  parameter int unsigned GUARD_CYCLES = `HSMC_GUARD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic serRxd,
  output logic serTxd,
  input wire logic serRtsN,
  output logic serCtsN,
  // Rate command from the command parser
  input wire logic rateSetValid,
  input wire hsmc_pkg::hsmc_rate_t rateSet,
  // Link status from the radio side
  input wire logic linkUp,
  input wire logic remoteDisc,
  // Payload and command paths
  input wire hsmc_pkg::hsmc_byte_t txByte,
  output logic txReady,
  input wire logic rxAccept,
  output hsmc_pkg::hsmc_byte_t rxByte,
  output logic rxIsPayload,
  output logic escapeSeen,
  output hsmc_pkg::hsmc_mode_t mode
);
  logic [1:0] rstSync_r;
  logic rstN;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  // Rate selection and bit-time divider
  hsmc_pkg::hsmc_rate_t rate_r, rate_nxt;
  logic [13:0] bitDiv;
  always_comb begin
    rate_nxt = rate_r;
    if (rateSetValid && rateSet <= hsmc_pkg::RATE_115200) begin
      rate_nxt = rateSet;
    end
    case (rate_r)
      hsmc_pkg::RATE_9600: bitDiv = 14'(`HSMC_DIV_9600);
      hsmc_pkg::RATE_19200: bitDiv = 14'(`HSMC_DIV_19200);
      hsmc_pkg::RATE_38400: bitDiv = 14'(`HSMC_DIV_38400);
      hsmc_pkg::RATE_57600: bitDiv = 14'(`HSMC_DIV_57600);
      hsmc_pkg::RATE_115200: bitDiv = 14'(`HSMC_DIV_115200);
      default: bitDiv = 14'(`HSMC_DIV_19200);
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rate_r <= hsmc_pkg::RATE_19200;
    end else begin
      rate_r <= rate_nxt;
    end
  end

  // Pin synchronisers, three stages; second and third must agree
  logic [2:0] rxSync_r, rtsSync_r;
  logic rxLine_r, rxLine_nxt, rtsN_r, rtsN_nxt;
  always_comb begin
    rxLine_nxt = (rxSync_r[1] == rxSync_r[2]) ? rxSync_r[2] : rxLine_r;
    rtsN_nxt = (rtsSync_r[1] == rtsSync_r[2]) ? rtsSync_r[2] : rtsN_r;
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rxSync_r <= 3'h7;
      rtsSync_r <= 3'h7;
      rxLine_r <= 1'b1;
      rtsN_r <= 1'b1;
    end else begin
      rxSync_r <= {rxSync_r[1:0], serRxd};
      rtsSync_r <= {rtsSync_r[1:0], serRtsN};
      rxLine_r <= rxLine_nxt;
      rtsN_r <= rtsN_nxt;
    end
  end

  // Receiver: 8N1, sampled at mid bit
  hsmc_pkg::hsmc_line_t rxSt_r, rxSt_nxt;
  logic [13:0] rxCnt_r, rxCnt_nxt;
  logic [2:0] rxBit_r, rxBit_nxt;
  logic [7:0] rxSh_r, rxSh_nxt;
  logic rxDone;
  hsmc_pkg::hsmc_byte_t rxByte_r, rxByte_nxt;
  always_comb begin
    rxSt_nxt = rxSt_r;
    rxCnt_nxt = rxCnt_r;
    rxBit_nxt = rxBit_r;
    rxSh_nxt = rxSh_r;
    rxDone = 1'b0;
    rxByte_nxt = rxByte_r;
    if (rxAccept) begin
      rxByte_nxt.valid = 1'b0;
    end
    case (rxSt_r)
      hsmc_pkg::LINE_IDLE: begin
        if (!rxLine_r) begin
          rxSt_nxt = hsmc_pkg::LINE_START;
          rxCnt_nxt = bitDiv >> 1;
        end
      end
      hsmc_pkg::LINE_START: begin
        if (rxCnt_r != 14'h0) begin
          rxCnt_nxt = rxCnt_r - 14'h1;
        end else if (rxLine_r) begin
          rxSt_nxt = hsmc_pkg::LINE_IDLE;
        end else begin
          rxSt_nxt = hsmc_pkg::LINE_DATA;
          rxCnt_nxt = bitDiv - 14'h1;
          rxBit_nxt = 3'h0;
        end
      end
      hsmc_pkg::LINE_DATA: begin
        if (rxCnt_r != 14'h0) begin
          rxCnt_nxt = rxCnt_r - 14'h1;
        end else begin
          rxSh_nxt = {rxLine_r, rxSh_r[7:1]};
          rxCnt_nxt = bitDiv - 14'h1;
          rxBit_nxt = rxBit_r + 3'h1;
          if (rxBit_r == 3'(`HSMC_DATA_BITS - 1)) begin
            rxSt_nxt = hsmc_pkg::LINE_STOP;
          end
        end
      end
      hsmc_pkg::LINE_STOP: begin
        if (rxCnt_r != 14'h0) begin
          rxCnt_nxt = rxCnt_r - 14'h1;
        end else begin
          rxSt_nxt = hsmc_pkg::LINE_IDLE;
          if (rxLine_r) begin
            rxDone = 1'b1;
            rxByte_nxt.valid = 1'b1;
            rxByte_nxt.data = rxSh_r;
          end
        end
      end
      default: rxSt_nxt = hsmc_pkg::LINE_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rxSt_r <= hsmc_pkg::LINE_IDLE;
      rxCnt_r <= 14'h0;
      rxBit_r <= 3'h0;
      rxSh_r <= 8'h00;
      rxByte_r <= '0;
    end else begin
      rxSt_r <= rxSt_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxBit_r <= rxBit_nxt;
      rxSh_r <= rxSh_nxt;
      rxByte_r <= rxByte_nxt;
    end
  end

  // Transmitter: 8N1, held off while host raises request-to-send
  hsmc_pkg::hsmc_line_t txSt_r, txSt_nxt;
  logic [13:0] txCnt_r, txCnt_nxt;
  logic [2:0] txBit_r, txBit_nxt;
  logic [7:0] txSh_r, txSh_nxt;
  logic txd_r, txd_nxt, txRdy_r, txRdy_nxt;
  always_comb begin
    txSt_nxt = txSt_r;
    txCnt_nxt = txCnt_r;
    txBit_nxt = txBit_r;
    txSh_nxt = txSh_r;
    txd_nxt = txd_r;
    txRdy_nxt = 1'b0;
    case (txSt_r)
      hsmc_pkg::LINE_IDLE: begin
        txd_nxt = 1'b1;
        txRdy_nxt = !rtsN_r;
        if (txRdy_r && txByte.valid) begin
          txSh_nxt = txByte.data;
          txSt_nxt = hsmc_pkg::LINE_START;
          txCnt_nxt = bitDiv - 14'h1;
          txd_nxt = 1'b0;
          txRdy_nxt = 1'b0;
        end
      end
      hsmc_pkg::LINE_START, hsmc_pkg::LINE_DATA: begin
        if (txCnt_r != 14'h0) begin
          txCnt_nxt = txCnt_r - 14'h1;
        end else begin
          txCnt_nxt = bitDiv - 14'h1;
          if (txSt_r == hsmc_pkg::LINE_START) begin
            txBit_nxt = 3'h0;
            txSt_nxt = hsmc_pkg::LINE_DATA;
            txd_nxt = txSh_r[0];
          end else if (txBit_r == 3'(`HSMC_DATA_BITS - 1)) begin
            txSt_nxt = hsmc_pkg::LINE_STOP;
            txd_nxt = 1'b1;
          end else begin
            txBit_nxt = txBit_r + 3'h1;
            txd_nxt = txSh_r[txBit_r + 3'h1];
          end
        end
      end
      hsmc_pkg::LINE_STOP: begin
        if (txCnt_r != 14'h0) begin
          txCnt_nxt = txCnt_r - 14'h1;
        end else begin
          txSt_nxt = hsmc_pkg::LINE_IDLE;
        end
      end
      default: txSt_nxt = hsmc_pkg::LINE_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      txSt_r <= hsmc_pkg::LINE_IDLE;
      txCnt_r <= 14'h0;
      txBit_r <= 3'h0;
      txSh_r <= 8'h00;
      txd_r <= 1'b1;
      txRdy_r <= 1'b0;
    end else begin
      txSt_r <= txSt_nxt;
      txCnt_r <= txCnt_nxt;
      txBit_r <= txBit_nxt;
      txSh_r <= txSh_nxt;
      txd_r <= txd_nxt;
      txRdy_r <= txRdy_nxt;
    end
  end

  // Escape guard timer and plus matcher
  hsmc_pkg::hsmc_esc_t esc_r, esc_nxt;
  logic [26:0] guard_r, guard_nxt;
  logic guardDone, escHit_r, escHit_nxt;
  assign guardDone = (guard_r >= 27'(GUARD_CYCLES));
  always_comb begin
    esc_nxt = esc_r;
    escHit_nxt = 1'b0;
    // A frame on the line is not silence, so the guard stays cleared while one is received
    guard_nxt = (rxSt_r != hsmc_pkg::LINE_IDLE) ? 27'h0 : (guardDone ? guard_r : guard_r + 27'h1);
    if (rxDone) begin
      guard_nxt = 27'h0;
      if (rxSh_r != `HSMC_PLUS_CHAR) begin
        esc_nxt = hsmc_pkg::ESC_WAIT;
      end else begin
        case (esc_r)
          hsmc_pkg::ESC_WAIT: esc_nxt = guardDone ? hsmc_pkg::ESC_PLUS1 : hsmc_pkg::ESC_WAIT;
          hsmc_pkg::ESC_ARMED: esc_nxt = hsmc_pkg::ESC_PLUS1;
          hsmc_pkg::ESC_PLUS1: esc_nxt = hsmc_pkg::ESC_PLUS2;
          hsmc_pkg::ESC_PLUS2: esc_nxt = hsmc_pkg::ESC_PLUS3;
          default: esc_nxt = hsmc_pkg::ESC_WAIT;
        endcase
      end
    end else if (esc_r == hsmc_pkg::ESC_PLUS3 && guardDone) begin
      escHit_nxt = 1'b1;
      esc_nxt = hsmc_pkg::ESC_ARMED;
    end else if (esc_r == hsmc_pkg::ESC_WAIT && guardDone) begin
      esc_nxt = hsmc_pkg::ESC_ARMED;
    end
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      esc_r <= hsmc_pkg::ESC_WAIT;
      guard_r <= 27'h0;
      escHit_r <= 1'b0;
    end else begin
      esc_r <= esc_nxt;
      guard_r <= guard_nxt;
      escHit_r <= escHit_nxt;
    end
  end

  // Mode state and flow control
  hsmc_pkg::hsmc_mode_t mode_r, mode_nxt;
  logic cts_r, cts_nxt;
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      hsmc_pkg::MODE_OFFLINE: if (linkUp) mode_nxt = hsmc_pkg::MODE_ONLINE;
      hsmc_pkg::MODE_ONLINE: if (escHit_r || remoteDisc || !linkUp) mode_nxt = hsmc_pkg::MODE_OFFLINE;
      default: mode_nxt = hsmc_pkg::MODE_OFFLINE;
    endcase
    // Low while the receive holding slot is free or being drained
    cts_nxt = rxByte_nxt.valid;
  end
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      mode_r <= hsmc_pkg::MODE_OFFLINE;
      cts_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      cts_r <= cts_nxt;
    end
  end

  assign serTxd = txd_r;
  assign serCtsN = cts_r;
  assign txReady = txRdy_r;
  assign rxByte = rxByte_r;
  assign rxIsPayload = (mode_r == hsmc_pkg::MODE_ONLINE);
  assign escapeSeen = escHit_r;
  assign mode = mode_r;

  reset_mode_a: assert property (@(posedge sys_clk) $rose(rstN) |-> mode_r == hsmc_pkg::MODE_OFFLINE)
    else $error("mode not offline after reset");
  go_online_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    $rose(mode_r == hsmc_pkg::MODE_ONLINE) |-> $past(linkUp))
    else $error("online without link");
  leave_online_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    mode_r == hsmc_pkg::MODE_ONLINE && (escHit_r || remoteDisc || !linkUp) |=> mode_r == hsmc_pkg::MODE_OFFLINE)
    else $error("online not left");
  escape_guard_a: assert property (@(posedge sys_clk) disable iff (!rstN)
    escHit_nxt |-> guardDone && esc_r == hsmc_pkg::ESC_PLUS3 && rxSt_r == hsmc_pkg::LINE_IDLE)
    else $error("escape without trailing guard");
  guard_restart_a: assert property (@(posedge sys_clk) disable iff (!rstN) rxDone |=> guard_r == 27'h0)
    else $error("guard not restarted");
  rate_hold_a: assert property (@(posedge sys_clk) disable iff (!rstN) !rateSetValid |=> $stable(rate_r))
    else $error("rate changed without command");
  rate_legal_a: assert property (@(posedge sys_clk) disable iff (!rstN) rate_r <= hsmc_pkg::RATE_115200)
    else $error("illegal rate");
  rate_default_a: assert property (@(posedge sys_clk) $rose(rstN) |-> rate_r == hsmc_pkg::RATE_19200)
    else $error("rate default wrong");
  sequence startBit_s;
    txSt_r == hsmc_pkg::LINE_IDLE && txRdy_r && txByte.valid;
  endsequence
  tx_start_a: assert property (@(posedge sys_clk) disable iff (!rstN) startBit_s |=> !txd_r [*2])
    else $error("start bit missing");
  tx_rts_a: assert property (@(posedge sys_clk) disable iff (!rstN) txRdy_r |-> $past(!rtsN_r))
    else $error("sent while request-to-send high");
  rx_byte_a: assert property (@(posedge sys_clk) disable iff (!rstN) rxDone |=> rxByte_r.valid && serCtsN)
    else $error("received byte lost");
endmodule
`default_nettype wire

//--- hsmc_host_model.sv
// Host-side serial partner: 8N1 frames both ways, request-to-send
`timescale 1ns/1ns
`default_nettype none
`include "hsmc_regs.svh"
module hsmc_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial lines
  input wire logic serTxd,
  output var logic serRxd,
  output var logic serRtsN
);
  int bitDiv = `HSMC_DIV_115200;
  int lowCyc = 0;
  time t0 = 0;
  initial begin
    serRxd = 1'b1;
    serRtsN = 1'b0;
  end
  // Width of each low pulse, used to time the start bit
  always @(negedge serTxd) t0 = $time;
  always @(posedge serTxd) lowCyc = int'(($time - t0) / 10);
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serRxd <= f[i];
      repeat (bitDiv) @(posedge sys_clk);
    end
  endtask
  // Samples at mid bit, LSB first
  task automatic recv(output logic [7:0] b, output logic stopOk);
    @(negedge serTxd);
    repeat (bitDiv / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitDiv) @(posedge sys_clk);
      b[i] = serTxd;
    end
    repeat (bitDiv) @(posedge sys_clk);
    stopOk = serTxd;
  endtask
endmodule
`default_nettype wire

//--- host_serial_mode_control_tb.sv
// Self-checking bench for the host serial mode control block
`timescale 1ns/1ns
`default_nettype none
`include "hsmc_regs.svh"
module host_serial_mode_control_tb;
  localparam int GUARD = 2000;
  logic sys_clk = 1'b0, reset_n = 1'b0, serRxd, serTxd, serRtsN, serCtsN, txReady, rxIsPayload, escapeSeen;
  logic rateSetValid = 1'b0, linkUp = 1'b0, remoteDisc = 1'b0, rxAccept = 1'b0, stopOk;
  hsmc_pkg::hsmc_rate_t rateSet = hsmc_pkg::RATE_19200;
  hsmc_pkg::hsmc_byte_t txByte = '0, rxByte;
  hsmc_pkg::hsmc_mode_t mode;
  int err_total = 0, compares = 0, escCnt = 0, k = 0;
  int divs[5] = '{`HSMC_DIV_9600, `HSMC_DIV_19200, `HSMC_DIV_38400, `HSMC_DIV_57600, `HSMC_DIV_115200};
  logic [7:0] expQ[$];
  logic [7:0] got, rnd;
  logic expMode = 1'b0;
  hsmc_top #(.GUARD_CYCLES(GUARD)) u_hsmc_top (.sys_clk(sys_clk), .reset_n(reset_n), .serRxd(serRxd),
    .serTxd(serTxd), .serRtsN(serRtsN), .serCtsN(serCtsN), .rateSetValid(rateSetValid), .rateSet(rateSet),
    .linkUp(linkUp), .remoteDisc(remoteDisc), .txByte(txByte), .txReady(txReady), .rxAccept(rxAccept),
    .rxByte(rxByte), .rxIsPayload(rxIsPayload), .escapeSeen(escapeSeen), .mode(mode));
  hsmc_host_model u_hsmc_host_model (.sys_clk(sys_clk), .serTxd(serTxd), .serRxd(serRxd), .serRtsN(serRtsN));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (escapeSeen === 1'b1) escCnt++;
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Divider truncation can shift an edge by a cycle
  task automatic chk_span(string n, int e, int g);
    compares++;
    if (g < e - 1 || g > e + 1) begin
      err_total++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    tick(3);
    reset_n <= 1'b1;
    tick(4);
  endtask
  task automatic set_rate(int c);
    rateSet <= hsmc_pkg::hsmc_rate_t'(c[2:0]);
    rateSetValid <= 1'b1;
    tick(1);
    rateSetValid <= 1'b0;
  endtask
  task automatic tx_put(logic [7:0] b);
    int n;
    txByte <= {1'b1, b};
    n = 0;
    do begin
      tick(1);
      n++;
    end while (txReady !== 1'b1 && n < 20000);
    txByte <= '0;
  endtask
  task automatic tx_check(logic [7:0] b);
    fork
      tx_put(b);
      u_hsmc_host_model.recv(got, stopOk);
    join
    chk_byte("tx data", b, got);
    chk_bit("tx stop", 1'b1, stopOk);
  endtask
  task automatic host_send(logic [7:0] b);
    int n;
    expQ.push_back(b);
    u_hsmc_host_model.send(b);
    n = 0;
    while (rxByte.valid !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chk_byte("rx data", expQ.pop_front(), rxByte.data);
    chk_bit("payload flag", expMode, rxIsPayload);
    tick(2);
    chk_bit("cts busy", 1'b1, serCtsN);
    rxAccept <= 1'b1;
    tick(1);
    rxAccept <= 1'b0;
    tick(2);
    chk_bit("cts ready", 1'b0, serCtsN);
  endtask
  task automatic mode_is(int n, logic e);
    tick(n);
    chk_bit("mode", e, mode);
  endtask
  initial begin
    tick(150000);
    err_total++;
    end_sim();
  end
  initial begin
    rnd = 8'($urandom(57));
    // Code 7 is out of range, so 19200 must stay
    for (int i = 0; i < 6; i++) begin
      do_reset();
      set_rate(i == 5 ? 7 : i);
      u_hsmc_host_model.lowCyc = 0;
      tx_put(8'hFF);
      tick(divs[i == 5 ? 1 : i] + 20);
      chk_span("start bit", divs[i == 5 ? 1 : i], u_hsmc_host_model.lowCyc);
    end
    do_reset();
    chk_bit("mode after reset", 1'b0, mode);
    set_rate(4);
    host_send(8'($urandom));
    rnd = 8'($urandom);
    // Raised request-to-send must cross the synchroniser before a byte is offered
    u_hsmc_host_model.serRtsN <= 1'b1;
    tick(10);
    txByte <= {1'b1, rnd};
    tick(300);
    chk_bit("tx held", 1'b0, txReady);
    chk_bit("txd idle", 1'b1, serTxd);
    u_hsmc_host_model.serRtsN <= 1'b0;
    tx_check(rnd);
    linkUp <= 1'b1;
    mode_is(3, 1'b1);
    linkUp <= 1'b0;
    mode_is(3, 1'b0);
    linkUp <= 1'b1;
    mode_is(3, 1'b1);
    remoteDisc <= 1'b1;
    tick(1);
    remoteDisc <= 1'b0;
    linkUp <= 1'b0;
    mode_is(1, 1'b0);
    linkUp <= 1'b1;
    mode_is(3, 1'b1);
    expMode = 1'b1;
    host_send(8'h00);
    // Pluses right after a byte lack the leading silence
    for (int i = 0; i < 3; i++) host_send(8'h2B);
    tick(2 * GUARD);
    chk_byte("early escapes", 8'h00, 8'(escCnt));
    chk_bit("still online", 1'b1, mode);
    for (int i = 0; i < 3; i++) host_send(8'h2B);
    while (escapeSeen !== 1'b1 && k < GUARD + 400) begin
      tick(1);
      k++;
    end
    mode_is(1, 1'b0);
    chk_byte("guarded escapes", 8'h01, 8'(escCnt));
    host_send(8'hFF);
    end_sim();
  end
endmodule
`default_nettype wire
